// File: bbalu_regs.vh
// Purpose: Constants for the byte and bit execution unit.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses.
// Notes:   Opcode fields are matched against the top bits of the word.
`ifndef BBALU_REGS_VH
`define BBALU_REGS_VH

// Opcode field values
`define BBALU_OP_ADD_ACC_TO_FILE   6'h07
`define BBALU_OP_AND_ACC_WITH_FILE 6'h05
`define BBALU_OP_AND_IMM_WITH_ACC  6'h39
`define BBALU_OP_ADD_IMM_TO_ACC    5'h1F
`define BBALU_OP_FILE_BIT_CLEAR    4'h4
`define BBALU_OP_FILE_BIT_SET      4'h5
`define BBALU_OP_SKIP_IF_BIT_ZERO  4'h6
`define BBALU_OP_SKIP_IF_BIT_ONE   4'h7

// Field positions
`define BBALU_DEST_BIT  7
`define BBALU_BIT_HI    9
`define BBALU_BIT_LO    7
`define BBALU_ADDR_HI   6
`define BBALU_IMM_HI    7

// Address of the I/O port register
`define BBALU_IO_ADDR   7'h05

// Reset values
`define BBALU_ACC_RST   8'h00
`define BBALU_FILE_RST  8'h00
`define BBALU_FLAG_RST  1'b0

// Cycles taken by a skip test that skips
`define BBALU_SKIP_CYCLES 2

`endif

// File: bbalu_exec.v
// Purpose: Executes eight byte, bit and literal instructions of an
//          8-bit core: adds, ANDs, bit set/clear and bit-test skips.
// Assumes: One instruction per valid cycle; inputs synchronous to clock.
// Notes:   The file is 128 bytes of flops; one address is an I/O port.
//          A skip waits for the next valid word, so gaps are allowed.
// Notes on behaviour
// - Immediate add sums accumulator and 8-bit literal into accumulator; C, DC, Z.
// - File add sums accumulator and addressed file byte; C, DC, Z updated.
// - Destination bit 0 writes accumulator, 1 writes the file byte back.
// - File AND goes to chosen destination and updates only the zero flag.
// - Immediate AND writes accumulator and updates only the zero flag.
// - Bit clear forces the indexed file bit to 0; flags untouched.
// - Bit set forces the indexed file bit to 1; flags untouched.
// - Skip-if-zero with the bit at 1 lets the next instruction run.
// - Skip-if-zero with the bit at 0 squashes the next instruction.
// - Skip-if-one with the bit at 1 squashes the next instruction.
// - Bit tests change neither the file nor any flag.
// - Read-modify-write of the I/O port uses pin levels as source.
// - Skip-if-zero decodes as 01 10 then bit index and address.
// - Skip-if-one decodes as 01 11 then bit index and address.
`timescale 1ns/1ps
`include "bbalu_regs.vh"

module bbalu_exec (
    input  wire        clock,
    input  wire        rstn,
    input  wire        instr_valid,
    input  wire [13:0] instr,
    input  wire [7:0]  port_pins,
    input  wire [6:0]  peek_addr,
    output reg  [7:0]  acc,
    output reg         carry,
    output reg         half_carry_flag,
    output reg         zero,
    output reg         skip_next,
    output reg         exec_done,
    output reg         file_wr,
    output reg  [6:0]  file_wr_addr,
    output reg  [7:0]  file_wr_data,
    output reg  [7:0]  port_latch,
    output reg  [7:0]  peek_data
);

    // Instruction class positions
    localparam C_ADDI = 0;
    localparam C_ADDF = 1;
    localparam C_ANDI = 2;
    localparam C_ANDF = 3;
    localparam C_BCLR = 4;
    localparam C_BSET = 5;
    localparam C_TSTZ = 6;
    localparam C_TSTO = 7;

    // One-hot states
    localparam [1:0] ST_RUN    = 2'h1;
    localparam [1:0] ST_SQUASH = 2'h2;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [7:0] file_mem [0:127];
    reg  [7:0] cls;
    reg  [6:0] fidx;
    reg  [7:0] fval;
    reg  [7:0] mask;
    reg  [7:0] opnd;
    reg  [8:0] sum9;
    reg  [4:0] half5;
    reg  [7:0] res;
    reg  [7:0] next_acc;
    reg        next_carry;
    reg        next_half;
    reg        next_zero;
    reg        next_wr;
    reg  [7:0] next_wr_data;
    reg        next_done;

    // Classifies a word into one-hot instruction classes
    function [7:0] bbalu_decode;
        input [13:0] w;
        begin
            bbalu_decode = 8'h00;
            bbalu_decode[C_ADDI] = (w[13:9] == `BBALU_OP_ADD_IMM_TO_ACC);
            bbalu_decode[C_ADDF] = (w[13:8] == `BBALU_OP_ADD_ACC_TO_FILE);
            bbalu_decode[C_ANDI] = (w[13:8] == `BBALU_OP_AND_IMM_WITH_ACC);
            bbalu_decode[C_ANDF] = (w[13:8] == `BBALU_OP_AND_ACC_WITH_FILE);
            bbalu_decode[C_BCLR] = (w[13:10] == `BBALU_OP_FILE_BIT_CLEAR);
            bbalu_decode[C_BSET] = (w[13:10] == `BBALU_OP_FILE_BIT_SET);
            bbalu_decode[C_TSTZ] = (w[13:10] == `BBALU_OP_SKIP_IF_BIT_ZERO);
            bbalu_decode[C_TSTO] = (w[13:10] == `BBALU_OP_SKIP_IF_BIT_ONE);
        end
    endfunction

    // One bit set at the given index
    function [7:0] bbalu_mask;
        input [2:0] b;
        begin
            bbalu_mask = 8'h01 << b;
        end
    endfunction

    // High when a result byte is all zeros
    function bbalu_is_zero;
        input [7:0] v;
        begin
            bbalu_is_zero = (v == 8'h00);
        end
    endfunction

    // High when the masked bit of a byte is set
    function bbalu_bit_hit;
        input [7:0] v;
        input [7:0] m;
        begin
            bbalu_bit_hit = ((v & m) != 8'h00);
        end
    endfunction

    // Operand fetch and arithmetic
    always @*
    begin
        cls   = bbalu_decode(instr);
        fidx  = instr[`BBALU_ADDR_HI:0];
        fval  = (fidx == `BBALU_IO_ADDR) ? port_pins : file_mem[fidx];
        mask  = bbalu_mask(instr[`BBALU_BIT_HI:`BBALU_BIT_LO]);
        opnd  = (cls[C_ADDI] | cls[C_ANDI]) ? instr[`BBALU_IMM_HI:0] : fval;
        sum9  = {1'b0, acc} + {1'b0, opnd};
        half5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
        res   = acc & opnd;
    end

    // Next-state and result steering
    always @*
    begin
        next_state   = state;
        next_acc     = acc;
        next_carry   = carry;
        next_half    = half_carry_flag;
        next_zero    = zero;
        next_wr      = 1'b0;
        next_wr_data = fval;
        next_done    = 1'b0;
        if (instr_valid)
        begin
            case (state)
                ST_SQUASH:
                begin
                    // Discarded word runs as an idle slot
                    next_state = ST_RUN;
                    next_done  = 1'b1;
                end
                ST_RUN:
                begin
                    next_done = |cls;
                    case (cls)
                        8'h01:
                        begin
                            next_acc   = sum9[7:0];
                            next_carry = sum9[8];
                            next_half  = half5[4];
                            next_zero  = bbalu_is_zero(sum9[7:0]);
                        end
                        8'h02:
                        begin
                            next_carry = sum9[8];
                            next_half  = half5[4];
                            next_zero  = bbalu_is_zero(sum9[7:0]);
                            if (instr[`BBALU_DEST_BIT])
                            begin
                                next_wr      = 1'b1;
                                next_wr_data = sum9[7:0];
                            end
                            else
                            begin
                                next_acc = sum9[7:0];
                            end
                        end
                        8'h04:
                        begin
                            next_acc  = res;
                            next_zero = bbalu_is_zero(res);
                        end
                        8'h08:
                        begin
                            next_zero = bbalu_is_zero(res);
                            if (instr[`BBALU_DEST_BIT])
                            begin
                                next_wr      = 1'b1;
                                next_wr_data = res;
                            end
                            else
                            begin
                                next_acc = res;
                            end
                        end
                        8'h10:
                        begin
                            next_wr      = 1'b1;
                            next_wr_data = fval & ~mask;
                        end
                        8'h20:
                        begin
                            next_wr      = 1'b1;
                            next_wr_data = fval | mask;
                        end
                        8'h40:
                        begin
                            // Bit at 1 runs on; bit at 0 squashes
                            if (!bbalu_bit_hit(fval, mask))
                                next_state = ST_SQUASH;
                        end
                        8'h80:
                        begin
                            if (bbalu_bit_hit(fval, mask))
                                next_state = ST_SQUASH;
                        end
                        default:
                        begin
                            next_done = 1'b0;
                        end
                    endcase
                end
                default:
                begin
                    next_state = ST_RUN;
                end
            endcase
        end
    end

    // Core registers, all written at the end of the cycle
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            state           <= ST_RUN;
            acc             <= `BBALU_ACC_RST;
            carry           <= `BBALU_FLAG_RST;
            half_carry_flag <= `BBALU_FLAG_RST;
            zero            <= `BBALU_FLAG_RST;
            skip_next       <= 1'b0;
            exec_done       <= 1'b0;
            file_wr         <= 1'b0;
            file_wr_addr    <= 7'h00;
            file_wr_data    <= 8'h00;
            port_latch      <= `BBALU_FILE_RST;
            peek_data       <= 8'h00;
        end
        else
        begin
            state           <= next_state;
            acc             <= next_acc;
            carry           <= next_carry;
            half_carry_flag <= next_half;
            zero            <= next_zero;
            skip_next       <= next_state[1];
            exec_done       <= next_done;
            file_wr         <= next_wr;
            if (next_wr)
            begin
                file_wr_addr <= fidx;
                file_wr_data <= next_wr_data;
            end
            // Writes aimed at the I/O address land in the port latch
            if (next_wr && fidx == `BBALU_IO_ADDR)
                port_latch <= next_wr_data;
            // Debug read, one cycle behind the file
            if (peek_addr == `BBALU_IO_ADDR)
                peek_data <= port_latch;
            else
                peek_data <= file_mem[peek_addr];
        end
    end

    // File bytes; the I/O slot only shadows the port latch and is never read
    genvar g;
    generate
        for (g = 0; g < 128; g = g + 1)
        begin : gen_file
            if (g == `BBALU_IO_ADDR)
            begin : gen_io
                always @(posedge clock)
                begin
                    if (!rstn)
                        file_mem[g] <= `BBALU_FILE_RST;
                    else
                        file_mem[g] <= port_latch;
                end
            end
            else
            begin : gen_mem
                always @(posedge clock)
                begin
                    if (!rstn)
                        file_mem[g] <= `BBALU_FILE_RST;
                    else if (next_wr && {25'h0, fidx} == g)
                        file_mem[g] <= next_wr_data;
                end
            end
        end
    endgenerate

endmodule

// File: bbalu_exec_properties.sv
// Purpose: Port assertions for the byte and bit execution unit.
// Assumes: Synchronous active-low reset; one word taken per valid edge.
// Notes:   Skip decisions are judged at the I/O port address, where pins show.
`timescale 1ns/1ps
module bbalu_exec_chk (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0]  port_pins,
    input wire logic [6:0]  peek_addr,
    input wire logic [7:0]  acc,
    input wire logic        carry,
    input wire logic        half_carry_flag,
    input wire logic        zero,
    input wire logic        skip_next,
    input wire logic        exec_done,
    input wire logic        file_wr,
    input wire logic [6:0]  file_wr_addr,
    input wire logic [7:0]  file_wr_data,
    input wire logic [7:0]  port_latch,
    input wire logic [7:0]  peek_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // A word that is taken and not squashed
    sequence s_go; instr_valid && !skip_next; endsequence
    sequence s_keep; $stable(carry) && $stable(half_carry_flag) && $stable(zero); endsequence
    // Opcode classes
    property p_addimm; s_go ##0 instr[13:9] == 5'h1F
        |=> {carry, acc} == $past(acc) + $past(instr[7:0]) && zero == (acc == 8'h00); endproperty
    property p_dc; s_go ##0 instr[13:9] == 5'h1F
        |=> half_carry_flag == ({1'h0, $past(acc[3:0])} + $past(instr[3:0]) > 5'h0F); endproperty
    property p_andimm; s_go ##0 instr[13:8] == 6'h39 |=> acc == ($past(acc) & $past(instr[7:0]))
        && zero == (acc == 8'h00) && $stable(carry) && $stable(half_carry_flag); endproperty
    property p_dest0; s_go ##0 instr[13:10] == 4'h1 && instr[8] && !instr[7] |=> !file_wr; endproperty
    property p_dest1; s_go ##0 instr[13:10] == 4'h1 && instr[8] && instr[7] && instr[6:0] != 7'h05
        |=> file_wr && file_wr_addr == $past(instr[6:0]) && $stable(acc); endproperty
    property p_bitmod; s_go ##0 instr[13:11] == 3'h2 && instr[6:0] != 7'h05
        |=> (file_wr && file_wr_data[$past(instr[9:7])] == $past(instr[10])) ##0 s_keep; endproperty
    property p_test; s_go ##0 instr[13:11] == 3'h3 && instr[6:0] == 7'h05
        |=> skip_next == ($past(port_pins[instr[9:7]]) == $past(instr[10])); endproperty
    property p_testkeep; s_go ##0 instr[13:11] == 3'h3 |=> (!file_wr && $stable(acc)) ##0 s_keep; endproperty
    property p_squash; instr_valid && skip_next
        |=> (exec_done && !skip_next && !file_wr && $stable(acc)) ##0 s_keep; endproperty
    a_addimm: assert property (p_addimm) else $error("add immediate sum or zero wrong");
    a_dc: assert property (p_dc) else $error("half carry wrong");
    a_andimm: assert property (p_andimm) else $error("and immediate wrong");
    a_dest0: assert property (p_dest0) else $error("file written with dest 0");
    a_dest1: assert property (p_dest1) else $error("file write missing with dest 1");
    a_bitmod: assert property (p_bitmod) else $error("bit modify wrong");
    a_test: assert property (p_test) else $error("skip decision wrong");
    a_testkeep: assert property (p_testkeep) else $error("bit test changed state");
    a_squash: assert property (p_squash) else $error("squashed word had effect");
endmodule

bind bbalu_exec bbalu_exec_chk bbalu_exec_chk_i (.clock(clock), .rstn(rstn), .instr_valid(instr_valid),
    .instr(instr), .port_pins(port_pins), .peek_addr(peek_addr), .acc(acc), .carry(carry),
    .half_carry_flag(half_carry_flag), .zero(zero), .skip_next(skip_next), .exec_done(exec_done),
    .file_wr(file_wr), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .port_latch(port_latch), .peek_data(peek_data));

// File: bbalu_exec_tb_top.sv
// Purpose: Self-checking bench for the byte and bit execution unit.
// Assumes: Outputs settle one edge after a word is taken.
// Notes:   Ordinary words run from a table; skips and port cases follow.
`timescale 1ns/1ps
module bbalu_exec_tb_top;
    logic        clock, rstn, instr_valid, carry, half_carry_flag, zero, skip_next, exec_done, file_wr;
    logic [13:0] instr;
    logic [7:0]  port_pins, acc, file_wr_data, port_latch, peek_data;
    logic [6:0]  peek_addr, file_wr_addr;
    int          fail_count = 0;
    int          n_checks = 0;
    int          i;
    logic [13:0] r_in [15] = '{14'h3EFF, 14'h3E01, 14'h3F08, 14'h3E08, 14'h390F, 14'h3E3C, 14'h07A0,
        14'h0720, 14'h0520, 14'h05A1, 14'h17A1, 14'h1120, 14'h0720, 14'h0721, 14'h3E10};
    // Expected accumulator, carry, half carry, zero
    logic [10:0] r_out [15] = '{11'h7F8, 11'h007, 11'h040, 11'h082, 11'h003, 11'h1E0, 11'h1E0,
        11'h3C2, 11'h1C2, 11'h1C3, 11'h1C3, 11'h1C3, 11'h382, 11'h780, 11'h005};

    bbalu_exec bbalu_exec_i (.clock(clock), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .port_pins(port_pins), .peek_addr(peek_addr), .acc(acc), .carry(carry),
        .half_carry_flag(half_carry_flag), .zero(zero), .skip_next(skip_next), .exec_done(exec_done),
        .file_wr(file_wr), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .port_latch(port_latch), .peek_data(peek_data));

    // Clock at 40 MHz
    initial
    begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One word for one cycle, then look just after the answering edge
    task exe(input logic [13:0] w);
        @(posedge clock);
        instr_valid <= 1'h1;
        instr <= w;
        @(posedge clock);
        instr_valid <= 1'h0;
        #1;
    endtask

    // Bit test at the port address, then an increment that may be squashed
    task tst(input logic [13:0] w, input logic s);
        logic [7:0] a;
        exe(w);
        a = acc;
        chk("skip_next", skip_next, s);
        exe(14'h3E01);
        chk("acc after test", acc, a + (s ? 8'h00 : 8'h01));
        chk("exec_done", exec_done, 1'h1);
    endtask

    task pk(input logic [6:0] a, input logic [7:0] e);
        @(posedge clock);
        peek_addr <= a;
        repeat (2) @(posedge clock);
        #1;
        chk("peek_data", peek_data, e);
    endtask

    // Main sequence
    initial
    begin
        rstn = 1'h0;
        instr_valid = 1'h0;
        instr = 14'h0000;
        port_pins = 8'hA5;
        peek_addr = 7'h00;
        repeat (8) @(posedge clock);
        rstn <= 1'h1;
        #1;
        chk("reset state", {acc, carry, half_carry_flag, zero, skip_next, port_latch}, 16'h0000);
        for (i = 0; i < 15; i++)
        begin
            exe(r_in[i]);
            chk("acc and flags", {acc, carry, half_carry_flag, zero}, r_out[i]);
            chk("exec_done", exec_done, 1'h1);
        end
        pk(7'h20, 8'h38);
        pk(7'h21, 8'h80);
        exe(14'h07A2);
        chk("file write", {file_wr, file_wr_addr, file_wr_data}, 16'hA200);
        exe(14'h1485);
        chk("port_latch", port_latch, 8'hA7);
        exe(14'h1005);
        chk("port_latch", port_latch, 8'hA4);
        tst(14'h1885, 1'h1);
        tst(14'h1C05, 1'h1);
        tst(14'h1805, 1'h0);
        tst(14'h1C85, 1'h0);
        exe(14'h3000);
        chk("unsupported", {exec_done, acc}, 16'h0002);
        @(posedge clock);
        rstn <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
        chk("mid reset", {acc, port_latch}, 16'h0000);
        @(posedge clock);
        rstn <= 1'h1;
        exe(14'h3E05);
        chk("acc after reset", {acc, carry, half_carry_flag, zero}, 11'h028);
        pk(7'h20, 8'h00);
        finish_test;
    end

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clock);
        fail_count++;
        finish_test;
    end
endmodule
